// file: rtl/fcm_pkg.sv
// package of the fuse controller configuration front end
// assumes a single 10 MHz clock domain and a word-wide register port
package fcm_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FCM_OFS_MODE = 8'h00;
    localparam logic [7:0] FCM_OFS_SRD_LOCK = 8'h04;
    localparam logic [7:0] FCM_OFS_SPG_LOCK = 8'h08;
    localparam logic [7:0] FCM_OFS_NRD_LOCK = 8'h0C;
    localparam logic [7:0] FCM_OFS_NPG_LOCK = 8'h10;
    localparam logic [7:0] FCM_OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] FCM_OFS_IRQ_ST = 8'h18;
    localparam logic [7:0] FCM_OFS_USER = 8'h1C;
    localparam logic [7:0] FCM_OFS_AUTO = 8'h24;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FCM_MODE_SW = 0;
    localparam int FCM_MODE_CSB_POL = 1;
    localparam int FCM_MODE_PGENB_POL = 2;
    localparam int FCM_MODE_LOAD_POL = 3;
    localparam int FCM_MODE_STROBE_POL = 4;
    localparam int FCM_MODE_PG_EN = 5;
    localparam int FCM_MODE_RD_EN = 6;
    localparam logic [6:0] FCM_MODE_RST = 7'h06;
    localparam int FCM_USR_CSB = 0;
    localparam int FCM_USR_STROBE = 1;
    localparam int FCM_USR_LOAD = 2;
    localparam int FCM_USR_PGENB = 3;
    localparam int FCM_ADDR_LSB = 16;
    localparam logic [3:0] FCM_USR_RST = 4'h9;
    localparam int FCM_AUTO_ENB = 0;
    localparam int FCM_AUTO_READ = 1;
    localparam int FCM_IRQ_W = 13;
    // status and enable bit positions
    localparam int FCM_EV_DONE = 0;
    localparam int FCM_EV_SEQ_NS_X = 1;
    localparam int FCM_EV_SEQ_S_X = 2;
    localparam int FCM_EV_SW_NS_X = 3;
    localparam int FCM_EV_SW_S_X = 4;
    localparam int FCM_EV_SEQ_NS_RD = 5;
    localparam int FCM_EV_SW_NS_RD = 9;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FCM_CLK_NS = 100;
    localparam int FCM_PROG_STROBE_NS = 10000;
    localparam int FCM_PROG_STROBE_CYC = (FCM_PROG_STROBE_NS + FCM_CLK_NS - 1) / FCM_CLK_NS;
    localparam int FCM_READ_STROBE_CYC = 2;
    localparam int FCM_SETUP_CYC = 1;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FCM_IDLE, FCM_SETUP, FCM_PULSE, FCM_HOLD} fcm_seq_t;
    typedef struct packed {
        logic [9:0] addr;
        logic csb;
        logic strobe;
        logic load;
        logic pgenb;
    } fcm_macro_t;
    typedef struct packed {
        logic [6:0] mode;
        logic srd_lock;
        logic spg_lock;
        logic nrd_lock;
        logic npg_lock;
        logic [12:0] irq_en;
        logic [12:0] irq_st;
        logic [9:0] uaddr;
        logic [3:0] uctl;
        logic uarm;
        logic [9:0] aaddr;
        logic aread;
        logic aenb;
        fcm_seq_t seq;
        logic [7:0] cnt;
        fcm_macro_t mac;
        logic [31:0] rdata;
        logic irq;
    } fcm_state_t;
endpackage

// file: rtl/fcm_ctrl.sv
// fuse controller front end: mode, polarity, locks, interrupts, sequencer
// assumes the fuse macro samples its lines on this clock and the bus
// master follows the one-cycle strobe protocol with no wait states
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

module fcm_ctrl
    import fcm_pkg::*;
#(
    parameter int PROG_CYC = FCM_PROG_STROBE_CYC,
    parameter int READ_CYC = FCM_READ_STROBE_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_secure,
    input wire logic i_region_secure,
    output logic [31:0] o_rdata,
    output fcm_macro_t o_macro,
    output logic o_busy,
    output logic o_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // violation events for one access; cross-world wins over lock
    function automatic logic [12:0] fcm_viol(input logic sw, input logic rd,
        input logic sec, input logic reg_sec, input logic [3:0] lk);
        logic [12:0] ev;
        logic [1:0] ofs;
        int base;
        ev = '0;
        ofs = {sec, ~rd};
        base = sw ? FCM_EV_SW_NS_RD : FCM_EV_SEQ_NS_RD;
        if (sec != reg_sec) begin
            if (sw) ev[sec ? FCM_EV_SW_S_X : FCM_EV_SW_NS_X] = 1'b1;
            else ev[sec ? FCM_EV_SEQ_S_X : FCM_EV_SEQ_NS_X] = 1'b1;
        end else if (lk[ofs]) begin
            ev[base + int'(ofs)] = 1'b1;
        end
        return ev;
    endfunction

    // lock bits indexed by {secure, program}
    function automatic logic [3:0] fcm_locks(input fcm_state_t s);
        return {s.spg_lock, s.srd_lock, s.npg_lock, s.nrd_lock};
    endfunction

    fcm_state_t st_reg;
    fcm_state_t st_next;
    logic [12:0] ev_set;
    logic [12:0] ev_clr;
    logic sw_mode;
    logic a_rd, a_pg;
    logic [7:0] strobe_len;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        ev_set = '0;
        ev_clr = '0;
        sw_mode = st_reg.mode[FCM_MODE_SW];
        strobe_len = st_reg.aread ? 8'(READ_CYC) : 8'(PROG_CYC);
        a_rd = 1'b0;
        a_pg = 1'b0;
        st_next.rdata = '0;
        // register writes
        if (i_wr) begin
            case (i_addr)
                FCM_OFS_MODE: st_next.mode = i_wdata[6:0];
                FCM_OFS_SRD_LOCK: st_next.srd_lock = i_wdata[0];
                FCM_OFS_SPG_LOCK: st_next.spg_lock = i_wdata[0];
                FCM_OFS_NRD_LOCK: st_next.nrd_lock = i_wdata[0];
                FCM_OFS_NPG_LOCK: st_next.npg_lock = i_wdata[0];
                FCM_OFS_IRQ_EN: st_next.irq_en = i_wdata[12:0];
                FCM_OFS_IRQ_ST: ev_clr = i_wdata[12:0];
                FCM_OFS_USER: begin
                    st_next.uaddr = i_wdata[FCM_ADDR_LSB +: 10];
                    st_next.uctl = i_wdata[3:0];
                    // rising strobe request is checked once, then held
                    if (i_wdata[FCM_USR_STROBE] && !st_reg.uctl[FCM_USR_STROBE]) begin
                        a_rd = i_wdata[FCM_USR_LOAD] && i_wdata[FCM_USR_PGENB]
                            && !i_wdata[FCM_USR_CSB];
                        a_pg = !i_wdata[FCM_USR_LOAD] && !i_wdata[FCM_USR_PGENB]
                            && !i_wdata[FCM_USR_CSB];
                        if (a_rd || a_pg)
                            ev_set = fcm_viol(1'b1, a_rd, i_secure, i_region_secure,
                                fcm_locks(st_reg));
                        st_next.uarm = sw_mode && ev_set == '0
                            && ((a_rd && st_reg.mode[FCM_MODE_RD_EN])
                            || (a_pg && st_reg.mode[FCM_MODE_PG_EN]));
                        if (!sw_mode) ev_set = '0;
                    end
                end
                FCM_OFS_AUTO: begin
                    // settings are frozen while a sequence runs
                    if (st_reg.seq == FCM_IDLE && !sw_mode) begin
                        st_next.aaddr = i_wdata[FCM_ADDR_LSB +: 10];
                        st_next.aread = i_wdata[FCM_AUTO_READ];
                        if (i_wdata[FCM_AUTO_ENB]) begin
                            ev_set = fcm_viol(1'b0, i_wdata[FCM_AUTO_READ], i_secure,
                                i_region_secure, fcm_locks(st_reg));
                            if (ev_set == '0) begin
                                st_next.aenb = 1'b1;
                                st_next.seq = FCM_SETUP;
                                st_next.cnt = 8'(FCM_SETUP_CYC);
                            end
                        end
                    end
                end
                default: ;
            endcase
        end
        // register reads, answered one cycle later
        if (i_rd) begin
            case (i_addr)
                FCM_OFS_MODE: st_next.rdata = {25'h0, st_reg.mode};
                FCM_OFS_SRD_LOCK: st_next.rdata = {31'h0, st_reg.srd_lock};
                FCM_OFS_SPG_LOCK: st_next.rdata = {31'h0, st_reg.spg_lock};
                FCM_OFS_NRD_LOCK: st_next.rdata = {31'h0, st_reg.nrd_lock};
                FCM_OFS_NPG_LOCK: st_next.rdata = {31'h0, st_reg.npg_lock};
                FCM_OFS_IRQ_EN: st_next.rdata = {19'h0, st_reg.irq_en};
                FCM_OFS_IRQ_ST: st_next.rdata = {19'h0, st_reg.irq_st};
                FCM_OFS_USER: st_next.rdata = {6'h0, st_reg.uaddr, 12'h0, st_reg.uctl};
                FCM_OFS_AUTO: st_next.rdata = {6'h0, st_reg.aaddr, 14'h0,
                    st_reg.aread, st_reg.aenb};
                default: st_next.rdata = '0;
            endcase
        end
        // falling strobe request disarms the software strobe
        if (!st_next.uctl[FCM_USR_STROBE]) st_next.uarm = 1'b0;
        // a held strobe drops once its permit goes or its lines change, so an
        // armed read can never be turned into an unchecked program pulse
        if (st_reg.uarm && st_next.uarm) begin
            if (st_next.uctl != st_reg.uctl || !st_next.mode[FCM_MODE_SW])
                st_next.uarm = 1'b0;
            if (st_next.uctl[FCM_USR_LOAD] && !st_next.mode[FCM_MODE_RD_EN])
                st_next.uarm = 1'b0;
            if (!st_next.uctl[FCM_USR_LOAD] && !st_next.mode[FCM_MODE_PG_EN])
                st_next.uarm = 1'b0;
        end
        // automatic sequencer
        case (st_reg.seq)
            FCM_IDLE: ;
            FCM_SETUP: begin
                if (st_reg.cnt <= 8'h01) begin
                    st_next.seq = FCM_PULSE;
                    st_next.cnt = strobe_len;
                end else st_next.cnt = st_reg.cnt - 8'h01;
            end
            FCM_PULSE: begin
                if (st_reg.cnt <= 8'h01) begin
                    st_next.seq = FCM_HOLD;
                    st_next.cnt = 8'(FCM_SETUP_CYC);
                end else st_next.cnt = st_reg.cnt - 8'h01;
            end
            FCM_HOLD: begin
                if (st_reg.cnt <= 8'h01) begin
                    st_next.seq = FCM_IDLE;
                    st_next.aenb = 1'b0;
                    ev_set[FCM_EV_DONE] = 1'b1;
                end else st_next.cnt = st_reg.cnt - 8'h01;
            end
            default: st_next.seq = FCM_IDLE;
        endcase
        // set wins over a simultaneous write-one clear
        st_next.irq_st = (st_reg.irq_st & ~ev_clr) | ev_set;
        // macro lines
        if (st_next.mode[FCM_MODE_SW]) begin
            st_next.mac.addr = st_next.uaddr;
            st_next.mac.csb = st_next.uctl[FCM_USR_CSB];
            st_next.mac.load = st_next.uctl[FCM_USR_LOAD];
            st_next.mac.pgenb = st_next.uctl[FCM_USR_PGENB];
            // blocked strobe sits at its inactive level
            st_next.mac.strobe = st_next.uarm ? st_next.uctl[FCM_USR_STROBE]
                : st_next.mode[FCM_MODE_STROBE_POL];
        end else begin
            // logical assert xor polarity, standby when idle
            st_next.mac.addr = st_next.aaddr;
            st_next.mac.csb = (st_next.seq != FCM_IDLE)
                ^ st_next.mode[FCM_MODE_CSB_POL];
            st_next.mac.load = (st_next.seq != FCM_IDLE && st_next.aread)
                ^ st_next.mode[FCM_MODE_LOAD_POL];
            st_next.mac.pgenb = (st_next.seq != FCM_IDLE && !st_next.aread)
                ^ st_next.mode[FCM_MODE_PGENB_POL];
            st_next.mac.strobe = (st_next.seq == FCM_PULSE)
                ^ st_next.mode[FCM_MODE_STROBE_POL];
        end
        st_next.irq = |(st_next.irq_st & st_next.irq_en);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
            st_reg.mode <= FCM_MODE_RST;
            st_reg.uctl <= FCM_USR_RST;
            st_reg.seq <= FCM_IDLE;
            st_reg.mac.csb <= 1'b1;
            st_reg.mac.pgenb <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_macro = st_reg.mac;
    assign o_busy = st_reg.seq != FCM_IDLE;
    assign o_irq = st_reg.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_idle_standby;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!st_reg.mode[FCM_MODE_SW] && st_reg.seq == FCM_IDLE)
            |-> o_macro.csb == st_reg.mode[FCM_MODE_CSB_POL]
            && o_macro.strobe == st_reg.mode[FCM_MODE_STROBE_POL];
    endproperty
    a_idle_standby: assert property (p_idle_standby)
        else $error("auto idle lines not in standby");

    property p_rd_permit;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.mode[FCM_MODE_SW] && st_reg.uarm && o_macro.load)
            |-> st_reg.mode[FCM_MODE_RD_EN] || $past(st_reg.mode[FCM_MODE_RD_EN]);
    endproperty
    a_rd_permit: assert property (p_rd_permit)
        else $error("software read strobe without read permit");

    property p_pg_permit;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.mode[FCM_MODE_SW] && st_reg.uarm && !o_macro.load)
            |-> st_reg.mode[FCM_MODE_PG_EN] || $past(st_reg.mode[FCM_MODE_PG_EN]);
    endproperty
    a_pg_permit: assert property (p_pg_permit)
        else $error("software program strobe without program permit");

    property p_auto_strobe;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!st_reg.mode[FCM_MODE_SW] && st_reg.seq == FCM_PULSE)
            |-> o_macro.strobe != st_reg.mode[FCM_MODE_STROBE_POL];
    endproperty
    a_auto_strobe: assert property (p_auto_strobe)
        else $error("strobe not at active level during pulse");

    property p_lock_block;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_wr && i_addr == FCM_OFS_AUTO && i_wdata[FCM_AUTO_ENB] && !sw_mode
            && st_reg.seq == FCM_IDLE && i_secure && i_region_secure
            && i_wdata[FCM_AUTO_READ] && st_reg.srd_lock)
            |=> st_reg.seq == FCM_IDLE && st_reg.irq_st[FCM_EV_SEQ_NS_RD + 2];
    endproperty
    a_lock_block: assert property (p_lock_block)
        else $error("locked secure read was started");

    property p_cross;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_wr && i_addr == FCM_OFS_AUTO && i_wdata[FCM_AUTO_ENB] && !sw_mode
            && st_reg.seq == FCM_IDLE && !i_secure && i_region_secure)
            |=> !st_reg.aenb && st_reg.irq_st[FCM_EV_SEQ_NS_X];
    endproperty
    a_cross: assert property (p_cross)
        else $error("cross-world access not flagged");

    property p_done;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.seq == FCM_HOLD && st_reg.cnt <= 8'h01)
            |=> !st_reg.aenb && st_reg.irq_st[FCM_EV_DONE] && o_macro.csb
            == st_reg.mode[FCM_MODE_CSB_POL];
    endproperty
    a_done: assert property (p_done)
        else $error("sequence end did not clear enable or flag done");

    property p_w1c;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (i_wr && i_addr == FCM_OFS_IRQ_ST && i_wdata[0] && st_reg.seq != FCM_HOLD)
            |=> !st_reg.irq_st[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("done flag not cleared by write one");

    property p_irq;
        @(posedge i_mclk) disable iff (!i_rst_b)
        o_irq == |(st_reg.irq_st & st_reg.irq_en);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with enabled status");

    property p_sw_pass;
        @(posedge i_mclk) disable iff (!i_rst_b)
        st_reg.mode[FCM_MODE_SW] |-> o_macro.addr == st_reg.uaddr
            && o_macro.csb == st_reg.uctl[FCM_USR_CSB];
    endproperty
    a_sw_pass: assert property (p_sw_pass)
        else $error("software levels not passed to macro");

    property p_sw_blocked;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.mode[FCM_MODE_SW] && !st_reg.uarm)
            |-> o_macro.strobe == st_reg.mode[FCM_MODE_STROBE_POL];
    endproperty
    a_sw_blocked: assert property (p_sw_blocked)
        else $error("unarmed software strobe left its inactive level");

    property p_busy_frozen;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (st_reg.seq == FCM_SETUP || st_reg.seq == FCM_PULSE)
            |=> st_reg.aenb && $stable(st_reg.aaddr) && $stable(st_reg.aread);
    endproperty
    a_busy_frozen: assert property (p_busy_frozen)
        else $error("sequencer settings changed while running");

    property p_auto_lines;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!st_reg.mode[FCM_MODE_SW] && st_reg.seq == FCM_PULSE)
            |-> o_macro.csb != st_reg.mode[FCM_MODE_CSB_POL]
            && (o_macro.load != st_reg.mode[FCM_MODE_LOAD_POL]) == st_reg.aread
            && (o_macro.pgenb != st_reg.mode[FCM_MODE_PGENB_POL]) == !st_reg.aread;
    endproperty
    a_auto_lines: assert property (p_auto_lines)
        else $error("sequencer lines not in read or program combination");

endmodule

// file: bench/fcm_macro_model.sv
// behavioural fuse macro: counts read and program strobes on its lines
// assumes the controller drives registered lines on the rising clock edge
`timescale 1ns/1ps

module fcm_macro_model
    import fcm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire fcm_macro_t i_macro,
    output logic [7:0] o_rd_cnt,
    output logic [7:0] o_pg_cnt,
    output logic [7:0] o_bad_cnt
);
    // ------------------------------------------------------------
    // strobe edge decode
    // ------------------------------------------------------------
    logic strobe_q;

    // a selected strobe rise must meet one of the two legal line sets
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_q <= 1'b0;
            o_rd_cnt <= 8'h00;
            o_pg_cnt <= 8'h00;
            o_bad_cnt <= 8'h00;
        end else begin
            strobe_q <= i_macro.strobe;
            if (i_macro.strobe && !strobe_q && !i_macro.csb) begin
                if (i_macro.load && i_macro.pgenb) begin
                    o_rd_cnt <= o_rd_cnt + 8'h01;
                end else if (!i_macro.load && !i_macro.pgenb) begin
                    o_pg_cnt <= o_pg_cnt + 8'h01;
                end else begin
                    o_bad_cnt <= o_bad_cnt + 8'h01;
                end
            end
        end
    end
endmodule

// file: bench/fcm_ctrl_tb.sv
// self-checking bench of the fuse controller front end
// assumes a short program strobe (PROG_CYC 3) to keep the run brief
`timescale 1ns/1ps

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got %0h expected %0h", $time, (got), (exp)); end end

module fcm_ctrl_tb;
    import fcm_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_mclk, i_rst_b, i_wr, i_rd, i_secure, i_region_secure;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, v;
    fcm_macro_t o_macro;
    logic o_busy, o_irq;
    logic [7:0] rd_cnt, pg_cnt, bad_cnt, exp_rd, exp_pg;
    logic [9:0] fa;
    int n_errors, tests_run;
    logic [7:0] lk_ofs [4];
    logic [7:0] m_tab [3];

    fcm_ctrl #(.PROG_CYC(3), .READ_CYC(2)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_secure(i_secure),
        .i_region_secure(i_region_secure), .o_rdata(o_rdata), .o_macro(o_macro),
        .o_busy(o_busy), .o_irq(o_irq));
    fcm_macro_model u_macro (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_macro(o_macro),
        .o_rd_cnt(rd_cnt), .o_pg_cnt(pg_cnt), .o_bad_cnt(bad_cnt));

    // 100 ns clock
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // ------------------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    // read data are taken only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask
    // bounded wait for the sequencer to drop busy
    task automatic wait_idle();
        int k;
        for (k = 0; k < 300 && o_busy !== 1'b0; k++) begin
            @(posedge i_mclk);
            #1;
        end
        if (k == 300) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // standby levels: every line deasserted, so each pin shows its polarity bit
    function automatic logic [3:0] standby(input logic [7:0] m);
        return {m[FCM_MODE_CSB_POL], m[FCM_MODE_STROBE_POL], m[FCM_MODE_LOAD_POL],
            m[FCM_MODE_PGENB_POL]};
    endfunction
    function automatic logic [31:0] auto_word(input logic [9:0] a, input logic rdop);
        return {6'h00, a, 14'h0000, rdop, 1'b1};
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        tests_run = 0;
        exp_rd = 8'h00;
        exp_pg = 8'h00;
        lk_ofs = '{FCM_OFS_SRD_LOCK, FCM_OFS_SPG_LOCK, FCM_OFS_NRD_LOCK, FCM_OFS_NPG_LOCK};
        m_tab = '{8'h00, 8'h1E, 8'h06};
        {i_rst_b, i_wr, i_rd, i_secure, i_region_secure} = 5'h00;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        void'($urandom(54078));
        repeat (4) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1;
        // reset values and standby lines
        `CHK({o_macro.csb, o_macro.strobe, o_macro.load, o_macro.pgenb}, 4'h9)
        rd_chk(FCM_OFS_MODE, 32'h0000_0006);
        for (int i = 1; i < 7; i++) rd_chk(8'(i * 4), 32'h0000_0000);
        rd_chk(FCM_OFS_USER, 32'h0000_0009);
        rd_chk(FCM_OFS_AUTO, 32'h0000_0000);
        wr(8'h20, $urandom);
        rd_chk(8'h20, 32'h0000_0000);
        // random lock and enable contents, reserved bits read zero
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            wr(lk_ofs[i], v);
            rd_chk(lk_ofs[i], {31'h0, v[0]});
            wr(lk_ofs[i], 32'h0);
        end
        v = $urandom;
        wr(FCM_OFS_IRQ_EN, v);
        rd_chk(FCM_OFS_IRQ_EN, v & 32'h0000_1FFF);
        wr(FCM_OFS_IRQ_EN, 32'h0);
        // polarity per line at standby
        foreach (m_tab[i]) begin
            wr(FCM_OFS_MODE, {24'h0, m_tab[i]});
            repeat (2) @(posedge i_mclk);
            #1;
            `CHK({o_macro.csb, o_macro.strobe, o_macro.load, o_macro.pgenb}, standby(m_tab[i]))
        end
        // automatic read, then program, with completion flag masked first
        for (int op = 1; op >= 0; op--) begin
            fa = 10'($urandom);
            wr(FCM_OFS_AUTO, auto_word(fa, op[0]));
            `CHK(o_busy, 1'b1)
            `CHK(o_macro.addr, fa)
            wait_idle();
            if (op == 1) exp_rd++; else exp_pg++;
            rd_chk(FCM_OFS_AUTO, {6'h00, fa, 14'h0000, op[0], 1'b0});
            rd_chk(FCM_OFS_IRQ_ST, 32'h0000_0001);
            `CHK(o_irq, 1'b0)
        end
        wr(FCM_OFS_IRQ_EN, 32'h0000_0001);
        @(posedge i_mclk);
        #1;
        `CHK(o_irq, 1'b1)
        wr(FCM_OFS_IRQ_ST, 32'h0000_0001);
        @(posedge i_mclk);
        #1;
        `CHK(o_irq, 1'b0)
        rd_chk(FCM_OFS_IRQ_ST, 32'h0000_0000);
        // automatic locks and cross-world errors give no strobe but a flag
        wr(FCM_OFS_IRQ_EN, 32'h0000_1FFF);
        for (int i = 0; i < 6; i++) begin
            i_secure <= (i < 2) || (i == 5);
            i_region_secure <= (i < 2) || (i == 4);
            if (i < 4) wr(lk_ofs[i], 32'h1);
            fa = 10'($urandom);
            wr(FCM_OFS_AUTO, auto_word(fa, ~i[0]));
            repeat (3) @(posedge i_mclk);
            #1;
            `CHK(o_busy, 1'b0)
            `CHK(o_irq, 1'b1)
            rd_chk(FCM_OFS_AUTO, {6'h00, fa, 14'h0000, ~i[0], 1'b0});
            v = 32'h1 << ((i < 4) ? (7 - 2 * (i / 2) + (i % 2)) : (i - 3));
            rd_chk(FCM_OFS_IRQ_ST, v);
            wr(FCM_OFS_IRQ_ST, 32'h0000_1FFF);
            if (i < 4) wr(lk_ofs[i], 32'h0);
        end
        {i_secure, i_region_secure} <= 2'b00;
        // software mode: permits, raw levels and address pass-through
        wr(FCM_OFS_MODE, 32'h0000_0001);
        wr(FCM_OFS_AUTO, 32'h0000_0003);
        rd_chk(FCM_OFS_AUTO, {6'h00, fa, 16'h0000});
        fa = 10'($urandom);
        wr(FCM_OFS_USER, {6'h00, fa, 16'h000E});
        `CHK(o_macro.strobe, 1'b0)
        `CHK(o_macro.addr, fa)
        wr(FCM_OFS_USER, 32'h0000_0000);
        wr(FCM_OFS_USER, 32'h0000_0002);
        `CHK(o_macro.strobe, 1'b0)
        wr(FCM_OFS_USER, 32'h0000_000C);
        wr(FCM_OFS_MODE, 32'h0000_0041);
        wr(FCM_OFS_USER, 32'h0000_000E);
        `CHK({o_macro.csb, o_macro.strobe, o_macro.load, o_macro.pgenb}, 4'h7)
        exp_rd++;
        wr(FCM_OFS_MODE, 32'h0000_0001);
        `CHK(o_macro.strobe, 1'b0)
        wr(FCM_OFS_USER, 32'h0000_0000);
        wr(FCM_OFS_MODE, 32'h0000_0021);
        wr(FCM_OFS_USER, 32'h0000_0002);
        `CHK({o_macro.csb, o_macro.strobe, o_macro.load, o_macro.pgenb}, 4'h4)
        exp_pg++;
        wr(FCM_OFS_USER, 32'h0000_000C);
        rd_chk(FCM_OFS_IRQ_ST, 32'h0000_0000);
        // software mode lock and cross-world refusal
        wr(FCM_OFS_MODE, 32'h0000_0041);
        wr(FCM_OFS_NRD_LOCK, 32'h1);
        wr(FCM_OFS_USER, 32'h0000_000E);
        `CHK(o_macro.strobe, 1'b0)
        rd_chk(FCM_OFS_IRQ_ST, 32'h1 << FCM_EV_SW_NS_RD);
        wr(FCM_OFS_USER, 32'h0000_000C);
        wr(FCM_OFS_NRD_LOCK, 32'h0);
        wr(FCM_OFS_IRQ_ST, 32'h0000_1FFF);
        i_secure <= 1'b1;
        wr(FCM_OFS_USER, 32'h0000_000E);
        `CHK(o_macro.strobe, 1'b0)
        rd_chk(FCM_OFS_IRQ_ST, 32'h1 << FCM_EV_SW_S_X);
        `CHK(o_irq, 1'b1)
        @(posedge i_mclk);
        #1;
        `CHK(rd_cnt, exp_rd)
        `CHK(pg_cnt, exp_pg)
        `CHK(bad_cnt, 8'h00)
        give_verdict();
    end
endmodule
